/* hdl/mmrf_fabric.sv */
// Operation
// (R1) after reset the flash array also answers at address zero
// (R2) clearing bit zero of the remap control maps SRAM at address zero
// (R3) one shared bus for code and data, 8/16/32-bit transfers, 32-bit instructions
// (R4) multi-byte values are little-endian
// (R5) 126 kB flash usable, top 2 kB boot page reserved
// (R6) flash erase page is 512 bytes; lower 64 kB block is all user space
// (R7) each 32-bit flash fetch takes two consecutive 16-bit flash reads
// (R8) flash sustains full clock for 16-bit fetch, half for 32-bit fetch
// (R9) SRAM is 2k by 32 bits, one access per word at full clock
// (R10) register space occupies the top two pages, all non-core registers
// (R11) software should not touch unoccupied register locations
// (R12) fast bus register access takes one cycle, peripheral bus two
// (R13) peripherals go on the peripheral bus except flash control and GPIO; the code also puts register offsets 0x00xx and 0x02xx on the fast bus
// (R14) byte lanes for narrow transfers are chosen from low address bits
module mmrf_fabric (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // processor request
   input wire logic req_valid_i,
   input wire mmrf_pkg::mmrf_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [31:0] rsp_rdata_o,
   output logic rsp_error_o,
   // fast register bus
   output mmrf_pkg::mmrf_reg_req_t fast_req_o,
   input wire logic [31:0] fast_rdata_i,
   // peripheral register bus
   output mmrf_pkg::mmrf_reg_req_t periph_req_o,
   input wire logic [31:0] periph_rdata_i,
   // status
   output logic remap_flash_o,
   output logic boot_page_hit_o
);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   typedef enum {
      MMRF_ST_IDLE,
      MMRF_ST_FLASH_HI,
      MMRF_ST_FLASH_DONE,
      MMRF_ST_SRAM,
      MMRF_ST_FAST,
      MMRF_ST_PERIPH1,
      MMRF_ST_PERIPH2,
      MMRF_ST_ERR
   } mmrf_state_t;

   mmrf_state_t state_reg;
   logic remap_reg;
   mmrf_pkg::mmrf_req_t cur_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rsp_valid_reg;
   logic rsp_error_reg;

   logic [31:0] a;
   logic in_low;
   logic sram_own;
   logic in_sram;
   logic in_flash;
   logic in_regs;
   logic is_fast;
   logic low_to_flash;
   logic low_to_sram;
   logic [16:0] flash_off;
   logic [15:0] reg_off;
   logic [3:0] strb;
   logic [31:0] lane_wdata;

   assign a = req_i.addr;
   // the SRAM's own range takes precedence over the mirrored low window
   assign sram_own = (a >= mmrf_pkg::SRAM_BASE && a < mmrf_pkg::SRAM_BASE + 32'h2000);
   assign in_low = (a < mmrf_pkg::LOW_WIN_LIMIT) && !sram_own;
   assign low_to_flash = in_low && remap_reg; // see (R1)
   assign low_to_sram = in_low && !remap_reg; // see (R2)
   assign in_sram = low_to_sram || sram_own;
   assign in_flash = low_to_flash || (a >= mmrf_pkg::FLASH_BASE && a < mmrf_pkg::FLASH_BASE + 32'h2_0000);
   assign in_regs = (a >= mmrf_pkg::MAPREG_BASE); // see (R10)
   assign flash_off = low_to_flash ? a[16:0] : 17'(a - mmrf_pkg::FLASH_BASE);
   assign reg_off = a[15:0];
   assign is_fast = (reg_off >= mmrf_pkg::GPIO_BASE && reg_off < mmrf_pkg::GPIO_LIMIT)
                    || (reg_off >= mmrf_pkg::FLASH_CTL_BASE && reg_off < mmrf_pkg::FLASH_CTL_LIMIT)
                    || (reg_off[15:8] == 8'h00) || (reg_off[15:8] == 8'h02); // see (R13)

   // byte strobes and replicated write lanes
   always_comb begin
      case (req_i.size)
         mmrf_pkg::MMRF_SIZE_BYTE: strb = 4'h1 << a[1:0]; // see (R14)
         mmrf_pkg::MMRF_SIZE_HALF: strb = a[1] ? 4'hC : 4'h3; // see (R14)
         default: strb = 4'hF; // see (R3)
      endcase
      case (req_i.size)
         mmrf_pkg::MMRF_SIZE_BYTE: lane_wdata = {4{req_i.wdata[7:0]}};
         mmrf_pkg::MMRF_SIZE_HALF: lane_wdata = {2{req_i.wdata[15:0]}};
         default: lane_wdata = req_i.wdata;
      endcase
   end

   logic boot_hit;
   assign boot_hit = in_flash && (flash_off >= mmrf_pkg::FLASH_USER_LIMIT); // see (R5)

   // ---------------------------------------------------------------
   // memories
   // ---------------------------------------------------------------
   logic [15:0] flash_mem [mmrf_pkg::FLASH_HW]; // see (R6)
   logic [31:0] sram_q;
   logic [15:0] flash_q;
   logic [mmrf_pkg::FLASH_AW-1:0] flash_idx_reg;
   logic [mmrf_pkg::FLASH_AW-1:0] flash_rd_idx;
   logic [3:0] strb_reg;
   logic [31:0] wdata_reg;

   // one byte-wide array per lane, so each lane has a single writer
   for (genvar i = 0; i < 4; i++) begin : g_sram_lane
      logic [7:0] lane_mem [mmrf_pkg::SRAM_WORDS]; // see (R9)
      logic [7:0] lane_q;
      always_ff @(posedge clk_i) begin
         if (state_reg == MMRF_ST_IDLE && req_valid_i && in_sram && req_i.write && strb[i]) begin
            lane_mem[a[mmrf_pkg::SRAM_AW+1:2]] <= lane_wdata[8*i +: 8]; // see (R4)
         end
         lane_q <= lane_mem[a[mmrf_pkg::SRAM_AW+1:2]];
      end
      assign sram_q[8*i +: 8] = lane_q;
   end

   // flash holds its own halfword index; programming goes through its controller
   initial begin
      for (int i = 0; i < mmrf_pkg::FLASH_HW; i++) begin
         flash_mem[i] = 16'(i);
      end
   end
   assign flash_rd_idx = (state_reg != MMRF_ST_IDLE) ? flash_idx_reg
                         : (req_i.size == mmrf_pkg::MMRF_SIZE_WORD) ? flash_off[16:1] & 16'hFFFE : flash_off[16:1];

   always_ff @(posedge clk_i) begin
      flash_q <= flash_mem[flash_rd_idx];
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   logic accept;
   assign accept = (state_reg == MMRF_ST_IDLE) && req_valid_i;
   assign req_ready_o = (state_reg == MMRF_ST_IDLE);

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= MMRF_ST_IDLE;
         cur_reg <= '0;
         strb_reg <= 4'h0;
         wdata_reg <= 32'h0000_0000;
         flash_idx_reg <= '0;
      end else begin
         case (state_reg)
            MMRF_ST_IDLE: begin
               if (accept) begin
                  cur_reg <= req_i;
                  strb_reg <= strb;
                  wdata_reg <= lane_wdata;
                  flash_idx_reg <= flash_off[16:1] | 16'h0001; // see (R7)
                  if (in_flash && !req_i.write && !boot_hit) begin
                     if (req_i.size == mmrf_pkg::MMRF_SIZE_WORD) begin
                        state_reg <= MMRF_ST_FLASH_HI; // see (R7)
                     end else begin
                        state_reg <= MMRF_ST_FLASH_DONE; // see (R8)
                     end
                  end else if (in_sram) begin
                     state_reg <= MMRF_ST_SRAM;
                  end else if (in_regs && is_fast) begin
                     state_reg <= MMRF_ST_FAST; // see (R12)
                  end else if (in_regs) begin
                     state_reg <= MMRF_ST_PERIPH1; // see (R12)
                  end else begin
                     state_reg <= MMRF_ST_ERR;
                  end
               end
            end
            MMRF_ST_FLASH_HI: begin
               state_reg <= MMRF_ST_FLASH_DONE; // see (R7)
            end
            MMRF_ST_PERIPH1: state_reg <= MMRF_ST_PERIPH2;
            default: state_reg <= MMRF_ST_IDLE;
         endcase
      end
   end

   // remap bit lives in the system control block on the fast bus
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         remap_reg <= mmrf_pkg::REMAP_RESET; // see (R1)
      end else if (accept && in_regs && req_i.write && reg_off == mmrf_pkg::REMAP_OFFSET && strb[0]) begin
         remap_reg <= req_i.wdata[mmrf_pkg::REMAP_BIT]; // see (R2)
      end
   end

   // ---------------------------------------------------------------
   // read data and answer
   // ---------------------------------------------------------------
   logic [15:0] flash_lo_reg;
   logic flash_second;
   assign flash_second = (state_reg == MMRF_ST_FLASH_DONE) && (cur_reg.size == mmrf_pkg::MMRF_SIZE_WORD);

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         flash_lo_reg <= 16'h0000;
      end else if (state_reg == MMRF_ST_FLASH_HI) begin
         flash_lo_reg <= flash_q;
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      case (state_reg)
         MMRF_ST_FLASH_DONE: rdata_next = flash_second ? {flash_q, flash_lo_reg} : {2{flash_q}}; // see (R4)
         MMRF_ST_SRAM: rdata_next = sram_q;
         MMRF_ST_FAST: rdata_next = (cur_reg.addr[15:0] == mmrf_pkg::REMAP_OFFSET)
                                    ? {31'h0, remap_reg} : fast_rdata_i;
         MMRF_ST_PERIPH2: rdata_next = periph_rdata_i;
         MMRF_ST_ERR: rdata_next = 32'h0000_0000;
         default: rdata_next = rdata_reg;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata_reg <= 32'h0000_0000;
         rsp_valid_reg <= 1'b0;
         rsp_error_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rsp_valid_reg <= (state_reg == MMRF_ST_FLASH_DONE) || (state_reg == MMRF_ST_SRAM)
                          || (state_reg == MMRF_ST_FAST) || (state_reg == MMRF_ST_PERIPH2)
                          || (state_reg == MMRF_ST_ERR);
         rsp_error_reg <= (state_reg == MMRF_ST_ERR);
      end
   end

   assign rsp_valid_o = rsp_valid_reg;
   assign rsp_rdata_o = rdata_reg;
   assign rsp_error_o = rsp_error_reg;
   assign remap_flash_o = remap_reg;
   assign boot_page_hit_o = boot_hit && accept;

   // register bus strobes: fast one cycle, peripheral held two
   always_comb begin
      fast_req_o = '0;
      periph_req_o = '0;
      fast_req_o.sel = (state_reg == MMRF_ST_FAST); // see (R12)
      fast_req_o.write = cur_reg.write;
      fast_req_o.addr = cur_reg.addr[15:0];
      fast_req_o.strb = strb_reg;
      fast_req_o.wdata = wdata_reg;
      periph_req_o.sel = (state_reg == MMRF_ST_PERIPH1) || (state_reg == MMRF_ST_PERIPH2);
      periph_req_o.write = cur_reg.write;
      periph_req_o.addr = cur_reg.addr[15:0];
      periph_req_o.strb = strb_reg;
      periph_req_o.wdata = wdata_reg;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_remap_reset;
      @(posedge clk_i) $rose(rst_n_reg) |-> remap_reg;
   endproperty
   a_remap_reset: assert property (p_remap_reset) else $error("remap not set after reset"); // see (R1)

   property p_remap_clear;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && in_regs && req_i.write && reg_off == mmrf_pkg::REMAP_OFFSET && strb[0] && !req_i.wdata[0]
         |=> !remap_reg;
   endproperty
   a_remap_clear: assert property (p_remap_clear) else $error("remap clear ignored"); // see (R2)

   property p_flash_two_reads;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && in_flash && !req_i.write && !boot_hit && req_i.size == mmrf_pkg::MMRF_SIZE_WORD
         |=> state_reg == MMRF_ST_FLASH_HI ##1 state_reg == MMRF_ST_FLASH_DONE ##1 rsp_valid_o;
   endproperty
   a_flash_two_reads: assert property (p_flash_two_reads) else $error("word flash fetch not two reads"); // see (R7)

   property p_flash_half;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && in_flash && !req_i.write && !boot_hit && req_i.size != mmrf_pkg::MMRF_SIZE_WORD
         |-> ##2 rsp_valid_o;
   endproperty
   a_flash_half: assert property (p_flash_half) else $error("half flash fetch slow"); // see (R8)

   property p_fast_one;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && in_regs && is_fast |=> fast_req_o.sel ##1 !fast_req_o.sel && rsp_valid_o;
   endproperty
   a_fast_one: assert property (p_fast_one) else $error("fast bus not one cycle"); // see (R12)

   property p_periph_two;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && in_regs && !is_fast |=> periph_req_o.sel [*2] ##1 rsp_valid_o;
   endproperty
   a_periph_two: assert property (p_periph_two) else $error("peripheral bus not two cycles"); // see (R12)

   property p_sram_one;
      @(posedge clk_i) disable iff (!rst_n_reg) accept && in_sram |-> ##2 rsp_valid_o;
   endproperty
   a_sram_one: assert property (p_sram_one) else $error("sram access not single"); // see (R9)

   property p_byte_strb;
      @(posedge clk_i) disable iff (!rst_n_reg)
         accept && req_i.size == mmrf_pkg::MMRF_SIZE_BYTE |=> $countones(strb_reg) == 1 && strb_reg[cur_reg.addr[1:0]];
   endproperty
   a_byte_strb: assert property (p_byte_strb) else $error("byte lane wrong"); // see (R14)

   property p_boot_refused;
      @(posedge clk_i) disable iff (!rst_n_reg) accept && boot_hit |=> state_reg == MMRF_ST_ERR;
   endproperty
   a_boot_refused: assert property (p_boot_refused) else $error("boot page reached"); // see (R5)

   c_flash_word: cover property (@(posedge clk_i) state_reg == MMRF_ST_FLASH_HI);
   c_periph: cover property (@(posedge clk_i) state_reg == MMRF_ST_PERIPH2);
   c_remap_sram: cover property (@(posedge clk_i) !remap_reg && accept && in_low);

endmodule : mmrf_fabric

/* hdl/mmrf_pkg.sv */
package mmrf_pkg;

   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
   localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
   localparam logic [31:0] MAPREG_BASE = 32'hFFFF_0000;
   localparam logic [31:0] LOW_WIN_LIMIT = 32'h0002_0000;
   localparam int SRAM_WORDS = 2048;
   localparam int SRAM_AW = 11;
   localparam int FLASH_HW = 65536;
   localparam int FLASH_AW = 16;
   localparam int FLASH_PAGE_BYTES = 512;
   localparam logic [16:0] FLASH_USER_LIMIT = 17'h1F800;
   localparam logic [16:0] FLASH_LOW_BLOCK = 17'h10000;
   localparam logic [15:0] GPIO_BASE = 16'hF400;
   localparam logic [15:0] GPIO_LIMIT = 16'hF500;
   localparam logic [15:0] FLASH_CTL_BASE = 16'hF800;
   localparam logic [15:0] FLASH_CTL_LIMIT = 16'hF900;
   localparam logic [15:0] REMAP_OFFSET = 16'h0220;
   localparam int REMAP_BIT = 0;
   localparam logic REMAP_RESET = 1'b1;
   localparam int FAST_BUS_CYCLES = 1;
   localparam int PERIPH_BUS_CYCLES = 2;

   // ---------------------------------------------------------------
   // transfer types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MMRF_SIZE_BYTE,
      MMRF_SIZE_HALF,
      MMRF_SIZE_WORD,
      MMRF_SIZE_RSVD
   } mmrf_size_t;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      mmrf_size_t size;
      logic instr;
      logic [31:0] wdata;
   } mmrf_req_t;

   typedef struct packed {
      logic sel;
      logic write;
      logic [15:0] addr;
      logic [3:0] strb;
      logic [31:0] wdata;
   } mmrf_reg_req_t;

endpackage : mmrf_pkg

/* verification/mmrf_reg_partner.sv */
module mmrf_reg_partner (
   // clock
   input wire logic clk_i,
   // register buses from the fabric
   input wire mmrf_pkg::mmrf_reg_req_t fast_req_i,
   input wire mmrf_pkg::mmrf_reg_req_t periph_req_i,
   output logic [31:0] fast_rdata_o,
   output logic [31:0] periph_rdata_o,
   // observation of the last write and select lengths
   output logic [31:0] fast_wdata_o,
   output logic [15:0] fast_waddr_o,
   output logic [31:0] periph_wdata_o,
   output logic [15:0] periph_waddr_o,
   output logic [2:0] fast_len_o,
   output logic [2:0] periph_len_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [2:0] fast_run_reg = 3'h0;
   logic [2:0] periph_run_reg = 3'h0;

   // ---------------------------------------------------------------
   // read data, scrambled outside the sampling cycle
   // ---------------------------------------------------------------
   assign fast_rdata_o = fast_req_i.sel ? {16'h5A5A, fast_req_i.addr} : ~{16'h5A5A, fast_req_i.addr};
   assign periph_rdata_o = (periph_req_i.sel && periph_run_reg == 3'h1) ?
      {16'hA5A5, periph_req_i.addr} : ~{16'hA5A5, periph_req_i.addr};

   // ---------------------------------------------------------------
   // select length and write capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (fast_req_i.sel) begin
         fast_run_reg <= fast_run_reg + 3'h1;
         if (fast_req_i.write) begin
            fast_wdata_o <= fast_req_i.wdata;
            fast_waddr_o <= fast_req_i.addr;
         end
      end else begin
         if (fast_run_reg != 3'h0) fast_len_o <= fast_run_reg;
         fast_run_reg <= 3'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (periph_req_i.sel) begin
         periph_run_reg <= periph_run_reg + 3'h1;
         if (periph_req_i.write && periph_run_reg == 3'h1) begin
            periph_wdata_o <= periph_req_i.wdata;
            periph_waddr_o <= periph_req_i.addr;
         end
      end else begin
         if (periph_run_reg != 3'h0) periph_len_o <= periph_run_reg;
         periph_run_reg <= 3'h0;
      end
   end
endmodule : mmrf_reg_partner

/* verification/test_memory_map_remap_fabric.sv */
module test_memory_map_remap_fabric;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_i, reset_n_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_error_o, remap_flash_o, boot_page_hit_o;
   mmrf_pkg::mmrf_req_t req_i;
   logic [31:0] rsp_rdata_o, fast_rdata, periph_rdata, fast_wdata, periph_wdata, rd;
   mmrf_pkg::mmrf_reg_req_t fast_req, periph_req;
   logic [15:0] fast_waddr, periph_waddr;
   logic [2:0] fast_len, periph_len;
   logic err, hit;
   int mismatches = 0, total_checks = 0, cycle_count = 0, lat;

   mmrf_fabric u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o),
      .fast_req_o(fast_req), .fast_rdata_i(fast_rdata), .periph_req_o(periph_req), .periph_rdata_i(periph_rdata),
      .remap_flash_o(remap_flash_o), .boot_page_hit_o(boot_page_hit_o));

   mmrf_reg_partner u_partner (.clk_i(clk_i), .fast_req_i(fast_req), .periph_req_i(periph_req),
      .fast_rdata_o(fast_rdata), .periph_rdata_o(periph_rdata), .fast_wdata_o(fast_wdata),
      .fast_waddr_o(fast_waddr), .periph_wdata_o(periph_wdata), .periph_waddr_o(periph_waddr),
      .fast_len_o(fast_len), .periph_len_o(periph_len));

   // ---------------------------------------------------------------
   // clock, timeout and verdict
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   always @(posedge clk_i) begin
      cycle_count++;
      if (cycle_count == 5000) begin
         mismatches++;
         $display("[ERR] %0t run did not finish", $time);
         results();
      end
   end

   // ---------------------------------------------------------------
   // processor side transfer and compare
   // ---------------------------------------------------------------
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic xfer(input logic [31:0] addr, input logic wr, input mmrf_pkg::mmrf_size_t sz,
                       input logic [31:0] wd);
      logic rdy;
      req_i.addr = addr;
      req_i.write = wr;
      req_i.size = sz;
      req_i.instr = ~wr;
      req_i.wdata = wd;
      req_valid_i = 1'b1;
      forever begin
         #1;
         rdy = req_ready_o;
         hit = boot_page_hit_o;
         @(posedge clk_i);
         if (rdy === 1'b1) break;
         @(negedge clk_i);
      end
      @(negedge clk_i);
      req_valid_i = 1'b0;
      req_i = ~req_i;
      // lat counts edges from the take edge up to the one that samples the answer, both included
      lat = 1;
      forever begin
         @(posedge clk_i);
         lat++;
         @(negedge clk_i);
         if (rsp_valid_o === 1'b1 || lat > 8) break;
      end
      rd = rsp_rdata_o;
      err = rsp_error_o;
   endtask : xfer

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      check(32'(remap_flash_o), 32'h1, "remap after reset");
      check(32'(req_ready_o), 32'h1, "ready after reset");
      $display("test reset done");
   endtask : t_reset

   task automatic t_sram_endian;
      xfer(mmrf_pkg::SRAM_BASE + 32'h40, 1'b1, mmrf_pkg::MMRF_SIZE_WORD, 32'h11223344);
      check(32'(lat), 32'h2, "sram latency");
      xfer(mmrf_pkg::SRAM_BASE + 32'h41, 1'b1, mmrf_pkg::MMRF_SIZE_BYTE, 32'h000000AB);
      xfer(mmrf_pkg::SRAM_BASE + 32'h42, 1'b1, mmrf_pkg::MMRF_SIZE_HALF, 32'h0000CDEF);
      xfer(mmrf_pkg::SRAM_BASE + 32'h40, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check(rd, 32'hCDEFAB44, "sram lanes");
      check(32'(err), 32'h0, "sram error");
      $display("test sram done");
   endtask : t_sram_endian

   task automatic t_flash;
      xfer(mmrf_pkg::FLASH_BASE, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check(32'(lat), 32'h3, "flash word latency");
      check(rd, 32'h0001_0000, "flash word halves");
      xfer(mmrf_pkg::FLASH_BASE + 32'h2, 1'b0, mmrf_pkg::MMRF_SIZE_HALF, 32'h0);
      check(32'(lat), 32'h2, "flash half latency");
      check(rd, 32'h0001_0001, "flash half replicated");
      xfer(mmrf_pkg::FLASH_BASE + 32'hFFFE, 1'b0, mmrf_pkg::MMRF_SIZE_HALF, 32'h0);
      check(32'(err), 32'h0, "lower block top");
      xfer(mmrf_pkg::FLASH_BASE + 32'h1F7FE, 1'b0, mmrf_pkg::MMRF_SIZE_HALF, 32'h0);
      check({err, hit}, 32'h0, "last user half");
      xfer(mmrf_pkg::FLASH_BASE + 32'h1F800, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check({err, hit}, 32'h3, "boot page refused");
      check(rd, 32'h0, "boot page data");
      xfer(mmrf_pkg::FLASH_BASE + 32'h200, 1'b1, mmrf_pkg::MMRF_SIZE_WORD, 32'h12345678);
      check(32'(err), 32'h1, "flash write refused");
      $display("test flash done");
   endtask : t_flash

   task automatic t_remap;
      xfer(mmrf_pkg::SRAM_BASE + 32'h8, 1'b1, mmrf_pkg::MMRF_SIZE_WORD, 32'h600DF00D);
      xfer(32'h8, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check(32'(lat), 32'h3, "zero mirrors flash");
      check(rd, 32'h0005_0004, "zero flash data");
      xfer(mmrf_pkg::MAPREG_BASE + 32'h220, 1'b1, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check({lat[1:0], remap_flash_o}, 32'h4, "remap cleared");
      xfer(32'h8, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check(rd, 32'h600DF00D, "zero maps sram");
      check(32'(lat), 32'h2, "zero sram latency");
      xfer(mmrf_pkg::MAPREG_BASE + 32'h220, 1'b1, mmrf_pkg::MMRF_SIZE_WORD, 32'h1);
      check(32'(remap_flash_o), 32'h1, "remap set again");
      $display("test remap done");
   endtask : t_remap

   task automatic t_regbus;
      logic [15:0] offs [4] = '{16'hF400, 16'hF800, 16'h0300, 16'h0500};
      // only occupied register offsets are touched
      for (int i = 0; i < 4; i++) begin
         xfer(mmrf_pkg::MAPREG_BASE + 32'(offs[i]), 1'b1, mmrf_pkg::MMRF_SIZE_WORD, {16'hC0DE, offs[i]});
         check(32'(lat), (i < 2) ? 32'h2 : 32'h3, "register write latency");
         check(i < 2 ? {fast_waddr, fast_wdata} : {periph_waddr, periph_wdata}, {offs[i], 16'hC0DE, offs[i]},
               "register write data");
         xfer(mmrf_pkg::MAPREG_BASE + 32'(offs[i]), 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
         check(rd, (i < 2) ? {16'h5A5A, offs[i]} : {16'hA5A5, offs[i]}, "register read data");
         check(32'(i < 2 ? fast_len : periph_len), (i < 2) ? 32'h1 : 32'h2, "select length");
      end
      xfer(32'h4000_0000, 1'b0, mmrf_pkg::MMRF_SIZE_WORD, 32'h0);
      check({rd[30:0], err}, 32'h1, "unmapped refused");
      $display("test register bus done");
   endtask : t_regbus

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n_i = 1'b0;
      req_valid_i = 1'b0;
      req_i = '0;
      repeat (16) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      t_reset();
      t_sram_endian();
      t_flash();
      t_remap();
      t_regbus();
      results();
   end
endmodule : test_memory_map_remap_fabric
